// ===== dv/adcls_chk.sv
// Port assertions for the channel list sequencer
`timescale 1ns/100ps
module adcls_chk
    import adcls_pkg::*;
(
    // Clock and resets
    input wire logic       sys_clk,
    input wire logic       rst_b,
    input wire logic       por_b,
    // Register bus
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    // Converter and stream
    input adcls_conv_t     conv_cmd,
    input wire logic       conv_start,
    input wire logic       conv_done,
    input adcls_sample_t   sample_out,
    input wire logic       sample_valid,
    input wire logic [1:0] dyn_dout
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////
    a_bus_answer: assert property ((avs_read || avs_write)
        |-> ##[0:2] !avs_waitrequest) else $error("bus request left waiting");
    a_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_result_cause: assert property (
        sample_valid && !sample_out.digital |-> $past(conv_done))
        else $error("analog result without conversion");
    a_digital_tag: assert property (
        sample_valid && sample_out.digital |-> sample_out.chan == CHAN_DIG)
        else $error("digital sample with wrong channel");
    a_no_dig_conv: assert property (
        conv_start |-> conv_cmd.chan != CHAN_DIG)
        else $error("conversion started for digital entry");
    a_chan_range: assert property (conv_start |->
        conv_cmd.chan <= (conv_cmd.diff ? CHAN_MAX_DIFF : CHAN_MAX_SE))
        else $error("conversion on channel out of range");
    a_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("start pulse longer than one cycle");
    a_valid_pulse: assert property (sample_valid |=> !sample_valid)
        else $error("sample valid longer than one cycle");
    a_dyn_hold: assert property (disable iff (!por_b)
        !rst_b |=> $stable(dyn_dout)) else $error("dynamic lines lost");
    a_dyn_clear: assert property (disable iff (1'b0)
        !por_b |=> dyn_dout == 2'h0) else $error("dynamic lines not clear");
endmodule : adcls_chk

// ===== dv/adcls_conv_model.sv
// Converter front end model answering each start pulse
`timescale 1ns/100ps
module adcls_conv_model
    import adcls_pkg::*;
(
    // Clock
    input wire logic            sys_clk,
    // Converter handshake
    input wire logic            conv_start,
    output logic                conv_done,
    output logic [SAMPLE_W-1:0] conv_data
);
    initial
    begin
        conv_done = 1'b0;
        conv_data = 16'h5a5a;
    end
    ////////////////////////////////////////
    // Prompt or slow answer; data churns while idle, holds during a conversion
    always
    begin
        @(posedge sys_clk);
        conv_data <= ~conv_data;
        if (conv_start === 1'b1)
        begin
            repeat ($urandom_range(8, 1)) @(posedge sys_clk);
            conv_done <= 1'b1;
            conv_data <= 16'($urandom);
            @(posedge sys_clk);
            conv_done <= 1'b0;
        end
    end
endmodule : adcls_conv_model

// ===== dv/adcls_seq_test.sv
// Self-checking testbench for the channel list sequencer
`timescale 1ns/100ps
module adcls_seq_test
    import adcls_pkg::*;
;
    logic                sys_clk = 1'b0;
    logic                rst_b = 1'b0;
    logic                por_b = 1'b0;
    logic [11:0]         avs_address = 12'h000;
    logic                avs_read = 1'b0;
    logic                avs_write = 1'b0;
    logic [31:0]         avs_writedata = 32'h0;
    logic [3:0]          avs_byteenable = 4'hf;
    logic [31:0]         avs_readdata;
    logic                avs_waitrequest;
    logic                sample_clk_in = 1'b1;
    logic                trigger_in = 1'b0;
    adcls_conv_t         conv_cmd;
    logic                conv_start;
    logic                conv_done;
    logic [SAMPLE_W-1:0] conv_data;
    logic [DIO_W-1:0]    dio_in = 16'h0;
    adcls_sample_t       sample_out;
    logic                sample_valid;
    logic [1:0]          dyn_dout;
    int                  mismatches = 0;
    int                  comparisons = 0;
    int                  cyc = 0;
    int                  len, rep, idx, pass;
    logic                run, trig, diff, bip, pend, dchk;
    logic [1:0]          dexp = 2'h0;
    logic [31:0]         rdat;
    adcls_entry_t        lst [0:7];
    adcls_conv_t         cmd_q [$];
    logic                inh_q [$];
    adcls_sample_t       smp_q [$];
    adcls_conv_t         pc;
    logic [5:0]          chs [0:5] = '{6'h00, 6'h1f, 6'h20,
                                       6'h0f, 6'h21, 6'h07};
    adcls_seq u_dut (
        .sys_clk, .rst_b, .por_b, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .sample_clk_in, .trigger_in, .conv_cmd, .conv_start, .conv_done,
        .conv_data, .dio_in, .sample_out, .sample_valid, .dyn_dout
    );
    adcls_conv_model u_conv (.sys_clk, .conv_start, .conv_done, .conv_data);
    always #12.5 sys_clk = ~sys_clk;
    ////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task end_sim();
        if (mismatches == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim
    task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do
            @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0 && ++n < 40);
        rdat = avs_readdata;
        if (n >= 40)
            chk(32'h0, 32'h1);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge sys_clk);
    endtask : bus
    // Model steps one entry, then the pin gives one falling edge
    task tick();
        logic [15:0]  dv;
        adcls_entry_t e;
        dv = 16'($urandom);
        dio_in <= dv;
        dchk = 1'b0;
        repeat (6) @(posedge sys_clk);
        if (run)
        begin
            e = lst[idx];
            dchk = e.chan == CHAN_DIG
                || e.chan <= (diff ? CHAN_MAX_DIFF : CHAN_MAX_SE);
            dexp = e.dout;
            if (dchk && e.chan == CHAN_DIG && !e.inhibit)
                smp_q.push_back({dv, e.chan, 1'b1});
            if (dchk && e.chan != CHAN_DIG)
            begin
                cmd_q.push_back({e.chan, e.gain, bip, diff});
                inh_q.push_back(e.inhibit);
            end
            idx = (idx + 1) % len;
            if (idx == 0 && trig && ++pass > rep)
                run = 1'b0;
        end
        sample_clk_in <= 1'b0;
        repeat (4) @(posedge sys_clk);
        sample_clk_in <= 1'b1;
        repeat (24) @(posedge sys_clk);
        chk(32'(dyn_dout), 32'(dexp));
    endtask : tick
    task fire();
        trigger_in <= 1'b1;
        repeat (6) @(posedge sys_clk);
        trigger_in <= 1'b0;
        repeat (6) @(posedge sys_clk);
        run = 1'b1;
        idx = 0;
        pass = 0;
    endtask : fire
    ////////////////////////////////////////
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (conv_start === 1'b1)
        begin
            pc = cmd_q.size() ? cmd_q.pop_front() : 'x;
            pend = inh_q.size() ? inh_q.pop_front() : 1'b1;
            chk(32'(conv_cmd), 32'(pc));
        end
        if (conv_done === 1'b1 && pend === 1'b0)
            smp_q.push_back({conv_data, pc.chan, 1'b0});
        if (sample_valid === 1'b1)
            chk(32'(sample_out),
                smp_q.size() ? 32'(smp_q.pop_front()) : 'x);
        if (cyc == 20000)
        begin
            mismatches++;
            end_sim();
        end
    end
    initial
    begin
        void'($urandom(32'hb05cde28));
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        por_b <= 1'b1;
        @(posedge sys_clk);
        bus(1'b0, REG_CTRL, 32'h0);
        chk(rdat, CTRL_RESET);
        bus(1'b0, REG_LIST_LEN, 32'h0);
        chk(rdat, 32'(LEN_RESET));
        bus(1'b0, 12'h0fc, 32'h0);
        chk(rdat, 32'(ST_IDLE));
        bus(1'b1, REG_REPEAT, 32'hff);
        bus(1'b0, REG_REPEAT, 32'h0);
        chk(rdat, 32'hff);
        bus(1'b1, REG_LIST_LEN, 32'd1024);
        bus(1'b0, REG_LIST_LEN, 32'h0);
        chk(rdat, 32'd1024);
        for (int s = 0; s < 2; s++)
        begin
            trig = s == 0;
            diff = s == 1;
            bip = s == 0;
            len = 5 - 2 * s;
            rep = 1 - s;
            bus(1'b1, REG_LIST_IDX, 32'h0);
            for (int i = 0; i < len; i++)
            begin
                lst[i] = 11'($urandom);
                lst[i].chan = chs[$urandom_range(5)];
                if (i == 0)
                    lst[i].chan = 6'($urandom_range(15));
                if (lst[i].chan == CHAN_DIG)
                    lst[i].gain = 2'h0;
                bus(1'b1, REG_LIST_DATA, {14'h0, lst[i].dout, 3'h0,
                    lst[i].inhibit, 2'h0, lst[i].gain, 2'h0, lst[i].chan});
            end
            bus(1'b0, REG_LIST_IDX, 32'h0);
            chk(rdat, 32'(len));
            bus(1'b1, REG_LIST_LEN, 32'(len));
            bus(1'b1, REG_REPEAT, 32'(rep));
            bus(1'b1, REG_LIST_IDX, 32'h0);
            bus(1'b1, REG_CTRL, {26'h0, 1'b1, bip, diff, trig, 2'b01});
            // Refused while armed; entry 0 would turn unusable
            bus(1'b1, REG_LIST_DATA, 32'h0000_0021);
            bus(1'b0, REG_LIST_IDX, 32'h0);
            chk(rdat, 32'h0);
            fire();
            repeat (len * (rep + 1) + 2) tick();
            if (trig)
            begin
                bus(1'b0, REG_STATUS, 32'h0);
                chk(rdat, 32'(rep << 12));
                fire();
                repeat (len) tick();
            end
            bus(1'b1, REG_CTRL, 32'h2);
            bus(1'b0, REG_DOUT, 32'h0);
            chk(rdat, 32'(dexp));
            run = 1'b0;
            tick();
        end
        rst_b <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        chk(32'(dyn_dout), 32'(dexp));
        por_b <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk(32'(dyn_dout), 32'h0);
        por_b <= 1'b1;
        repeat (30) @(posedge sys_clk);
        chk(32'(cmd_q.size() + smp_q.size()), 32'h0);
        end_sim();
    end
endmodule : adcls_seq_test
bind adcls_seq adcls_chk u_chk (
    .sys_clk, .rst_b, .por_b, .avs_read, .avs_write, .avs_waitrequest,
    .conv_cmd, .conv_start, .conv_done, .sample_out, .sample_valid,
    .dyn_dout
);

// ===== hdl/adcls_pkg.sv
// Package for the channel list sequencer: register map, fields, states
package adcls_pkg;

    localparam int          LIST_DEPTH    = 1024;
    localparam int          IDX_W         = 10;
    localparam int          CHAN_W        = 6;
    localparam logic [5:0]  CHAN_DIG      = 6'h20;
    localparam logic [5:0]  CHAN_MAX_SE   = 6'h1f;
    localparam logic [5:0]  CHAN_MAX_DIFF = 6'h0f;
    localparam int          SAMPLE_W      = 16;
    localparam int          DIO_W         = 16;
    localparam int          SAMPLES_PER_TICK = 1;

    // Register byte addresses (word aligned, 32-bit data)
    localparam logic [11:0] REG_CTRL      = 12'h000;
    localparam logic [11:0] REG_STATUS    = 12'h004;
    localparam logic [11:0] REG_LIST_LEN  = 12'h008;
    localparam logic [11:0] REG_REPEAT    = 12'h00c;
    localparam logic [11:0] REG_LIST_IDX  = 12'h010;
    localparam logic [11:0] REG_LIST_DATA = 12'h014;
    localparam logic [11:0] REG_DOUT      = 12'h018;

    // Control register fields
    localparam int CTRL_START_BIT     = 0;
    localparam int CTRL_STOP_BIT      = 1;
    localparam int CTRL_TRIGGERED_BIT = 2;
    localparam int CTRL_DIFF_BIT      = 3;
    localparam int CTRL_BIPOLAR_BIT   = 4;
    localparam int CTRL_DYN_EN_BIT    = 5;
    localparam int CTRL_RETRIG_BIT    = 6;

    // Entry fields within the list data word
    localparam int ENT_CHAN_LSB = 0;
    localparam int ENT_GAIN_LSB = 8;
    localparam int ENT_INH_BIT  = 12;
    localparam int ENT_DOUT_LSB = 16;

    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [7:0]  REPEAT_RESET = 8'h00;
    localparam logic [10:0] LEN_RESET    = 11'h001;

    typedef struct packed {
        logic [1:0]        dout;
        logic              inhibit;
        logic [1:0]        gain;
        logic [CHAN_W-1:0] chan;
    } adcls_entry_t;

    typedef struct packed {
        logic [CHAN_W-1:0] chan;
        logic [1:0]        gain;
        logic              bipolar;
        logic              diff;
    } adcls_conv_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0] data;
        logic [CHAN_W-1:0]   chan;
        logic                digital;
    } adcls_sample_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RUN  = 4'b0010,
        ST_CONV = 4'b0100,
        ST_WAIT = 4'b1000
    } adcls_state_t;

endpackage : adcls_pkg

// ===== hdl/adcls_seq.sv
// Channel list sequencer for the analog input subsystem
//
// Notes on behaviour
// - List memory holds up to 1024 entries
// - Entries processed in order, first to last
// - Triggered mode repeats list up to 256
// - Channels 0-31 single-ended, 0-15 differential
// - Any channel order and repeats accepted
// - Inhibited entry sampled, result discarded
// - Channel 32 captures 16 digital lines
// - Digital pseudo-channel allowed anywhere, same pacing
// - Dynamic outputs follow entry value when enabled
// - Bit 0 drives line 0, bit 1 line 1
// - Dynamic outputs zero at power-up, kept on reset
// - Per-entry gain 1, 2, 4 or 8
// - Range polarity is one shared setting
// - Conversion results fixed at 16 bits
// - Continuous scan wraps to first entry
// - Each sample clock pulse advances one entry
`timescale 1ns/100ps

module adcls_seq
    import adcls_pkg::*;
(
    // Clock, reset and power-on clear
    input  wire logic                 sys_clk,
    input  wire logic                 rst_b,
    input  wire logic                 por_b,
    // Avalon-MM slave
    input  wire logic [11:0]          avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic [31:0]               avs_readdata,
    output logic                      avs_waitrequest,
    // Pacing and trigger pins
    input  wire logic                 sample_clk_in,
    input  wire logic                 trigger_in,
    // Converter front end
    output adcls_conv_t               conv_cmd,
    output logic                      conv_start,
    input  wire logic                 conv_done,
    input  wire logic [SAMPLE_W-1:0]  conv_data,
    // Digital port pins
    input  wire logic [DIO_W-1:0]     dio_in,
    // Sample stream out
    output adcls_sample_t             sample_out,
    output logic                      sample_valid,
    // Dynamic digital outputs
    output logic [1:0]                dyn_dout
);

    ////////////////////////////////////////////////////////////////////
    // Declarations

    adcls_entry_t           list_mem [LIST_DEPTH];
    adcls_entry_t           cur_r;
    adcls_state_t           state_r;
    logic [31:0]            ctrl_r;
    logic [10:0]            len_r;
    logic [7:0]             repeat_r;
    logic [IDX_W-1:0]       load_idx_r;
    logic [IDX_W-1:0]       ptr_r;
    logic [7:0]             pass_r;
    logic [2:0]             clk_sync_r;
    logic [2:0]             trg_sync_r;
    logic [DIO_W-1:0]       dio_s1_r;
    logic [DIO_W-1:0]       dio_s2_r;
    logic [DIO_W-1:0]       dio_s3_r;
    logic                   clk_lvl_r;
    logic                   trg_lvl_r;
    logic                   tick;
    logic                   trig;
    logic                   bus_req_r;
    logic                   start_req;
    logic                   stop_req;
    logic                   last_entry;
    logic                   chan_ok;
    logic                   mem_we;
    adcls_entry_t           wr_entry;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers, level changes when second and third agree

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            clk_sync_r <= 3'h7;
            trg_sync_r <= 3'h0;
            clk_lvl_r  <= 1'b1;
            trg_lvl_r  <= 1'b0;
        end
        else
        begin
            clk_sync_r <= {clk_sync_r[1:0], sample_clk_in};
            trg_sync_r <= {trg_sync_r[1:0], trigger_in};
            if (clk_sync_r[1] == clk_sync_r[2])
                clk_lvl_r <= clk_sync_r[2];
            if (trg_sync_r[1] == trg_sync_r[2])
                trg_lvl_r <= trg_sync_r[2];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dio_s1_r <= '0;
            dio_s2_r <= '0;
            dio_s3_r <= '0;
        end
        else
        begin
            dio_s1_r <= dio_in;
            dio_s2_r <= dio_s1_r;
            dio_s3_r <= dio_s2_r;
        end
    end

    // Conversions start on the falling edge of the sample clock
    assign tick = clk_lvl_r && (clk_sync_r[1] == clk_sync_r[2])
                  && !clk_sync_r[2];
    assign trig = !trg_lvl_r && (trg_sync_r[1] == trg_sync_r[2])
                  && trg_sync_r[2];

    ////////////////////////////////////////////////////////////////////
    // Avalon-MM slave, one wait cycle per access

    assign start_req = avs_write && !avs_waitrequest
                       && (avs_address == REG_CTRL) && avs_byteenable[0]
                       && avs_writedata[CTRL_START_BIT];
    assign stop_req  = avs_write && !avs_waitrequest
                       && (avs_address == REG_CTRL) && avs_byteenable[0]
                       && avs_writedata[CTRL_STOP_BIT];
    assign mem_we    = avs_write && !avs_waitrequest
                       && (avs_address == REG_LIST_DATA)
                       && (state_r == ST_IDLE);

    always_comb
    begin
        wr_entry         = '0;
        wr_entry.chan    = avs_writedata[ENT_CHAN_LSB +: CHAN_W];
        wr_entry.gain    = avs_writedata[ENT_GAIN_LSB +: 2];
        wr_entry.inhibit = avs_writedata[ENT_INH_BIT];
        wr_entry.dout    = avs_writedata[ENT_DOUT_LSB +: 2];
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            bus_req_r <= 1'b0;
        else
            bus_req_r <= (avs_read || avs_write) && !bus_req_r;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !((avs_read || avs_write) && !bus_req_r);
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_r     <= CTRL_RESET;
            len_r      <= LEN_RESET;
            repeat_r   <= REPEAT_RESET;
            load_idx_r <= '0;
        end
        else if (avs_write && !avs_waitrequest)
        begin
            case (avs_address)
                REG_CTRL:
                    if (avs_byteenable[0])
                        ctrl_r <= {24'h0, 1'b0, avs_writedata[6:2], 2'h0};
                REG_LIST_LEN:
                    if (state_r == ST_IDLE)
                        len_r <= (avs_writedata[10:0] > 11'h400)
                                 ? 11'h400 : avs_writedata[10:0];
                REG_REPEAT:
                    if (avs_byteenable[0])
                        repeat_r <= avs_writedata[7:0];
                REG_LIST_IDX:
                    load_idx_r <= avs_writedata[IDX_W-1:0];
                REG_LIST_DATA:
                    if (state_r == ST_IDLE)
                        load_idx_r <= load_idx_r + 10'h001;
                default:
                    ;
            endcase
        end
    end

    // List storage, one entry per index
    always_ff @(posedge sys_clk)
    begin
        if (mem_we)
            list_mem[load_idx_r] <= wr_entry;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            avs_readdata <= '0;
        else if (avs_read && !bus_req_r)
        begin
            case (avs_address)
                REG_CTRL:      avs_readdata <= ctrl_r;
                REG_STATUS:    avs_readdata <= {12'h0, pass_r,
                                   2'h0, ptr_r};
                REG_LIST_LEN:  avs_readdata <= {21'h0, len_r};
                REG_REPEAT:    avs_readdata <= {24'h0, repeat_r};
                REG_LIST_IDX:  avs_readdata <= {22'h0, load_idx_r};
                REG_DOUT:      avs_readdata <= {30'h0, dyn_dout};
                default:       avs_readdata <= {28'h0, state_r};
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Scan sequencer

    assign last_entry = ({1'b0, ptr_r} == len_r - 11'h001);
    // Channel in range for input type; digital channel always allowed
    assign chan_ok = (cur_r.chan == CHAN_DIG)
                     || (ctrl_r[CTRL_DIFF_BIT]
                         ? (cur_r.chan <= CHAN_MAX_DIFF)
                         : (cur_r.chan <= CHAN_MAX_SE));

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= ST_IDLE;
            ptr_r   <= '0;
            pass_r  <= '0;
            cur_r   <= '0;
        end
        else if (stop_req)
            state_r <= ST_IDLE;
        else
        begin
            case (state_r)
                ST_IDLE:
                    if (start_req)
                    begin
                        ptr_r   <= '0;
                        pass_r  <= '0;
                        state_r <= ST_WAIT;
                    end
                ST_WAIT:
                    if (trig)
                    begin
                        ptr_r   <= '0;
                        pass_r  <= '0;
                        state_r <= ST_RUN;
                    end
                ST_RUN:
                    if (tick)
                    begin
                        cur_r   <= list_mem[ptr_r];
                        state_r <= ST_CONV;
                    end
                ST_CONV:
                    if (conv_done || cur_r.chan == CHAN_DIG
                        || !chan_ok)
                    begin
                        state_r <= ST_RUN;
                        if (!last_entry)
                            ptr_r <= ptr_r + 10'h001;
                        else
                        begin
                            ptr_r <= '0;
                            if (ctrl_r[CTRL_TRIGGERED_BIT])
                            begin
                                if (pass_r == repeat_r)
                                    state_r <= ST_WAIT;
                                else
                                    pass_r <= pass_r + 8'h01;
                            end
                        end
                    end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Converter command

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            conv_cmd   <= '0;
            conv_start <= 1'b0;
        end
        else
        begin
            // Digital and out-of-range entries start no conversion
            conv_start <= (state_r == ST_RUN) && tick && !stop_req
                          && (list_mem[ptr_r].chan <= (ctrl_r[CTRL_DIFF_BIT]
                              ? CHAN_MAX_DIFF : CHAN_MAX_SE));
            if ((state_r == ST_RUN) && tick)
            begin
                conv_cmd.chan    <= list_mem[ptr_r].chan;
                conv_cmd.gain    <= list_mem[ptr_r].gain;
                conv_cmd.bipolar <= ctrl_r[CTRL_BIPOLAR_BIT];
                conv_cmd.diff    <= ctrl_r[CTRL_DIFF_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sample output stream

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sample_out   <= '0;
            sample_valid <= 1'b0;
        end
        else
        begin
            sample_valid <= 1'b0;
            if (state_r == ST_CONV && !stop_req)
            begin
                if (cur_r.chan == CHAN_DIG)
                begin
                    sample_out.data    <= dio_s3_r;
                    sample_out.chan    <= cur_r.chan;
                    sample_out.digital <= 1'b1;
                    sample_valid       <= !cur_r.inhibit;
                end
                else if (conv_done && chan_ok)
                begin
                    sample_out.data    <= conv_data;
                    sample_out.chan    <= cur_r.chan;
                    sample_out.digital <= 1'b0;
                    sample_valid       <= !cur_r.inhibit;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Dynamic outputs, cleared only by power-on

    always_ff @(posedge sys_clk or negedge por_b)
    begin
        if (!por_b)
            dyn_dout <= 2'h0;
        else if (rst_b && state_r == ST_RUN && tick
                 && ctrl_r[CTRL_DYN_EN_BIT])
            dyn_dout <= list_mem[ptr_r].dout;
    end

endmodule : adcls_seq
